// [verilog/nv_pkg.sv]
// constants, offsets and state types of the data eeprom access control
package nv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PWRT_TIME_MS = 64;
  localparam int unsigned PWRT_CYCLES = PWRT_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned WRITE_TIME_US = 4;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES = WRITE_CYCLES / 2;
  localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);
  localparam logic [15:0] PROG_LAST = 16'(WRITE_CYCLES - ERASE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned BUS_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned FULL_DEPTH = 256;
  localparam int unsigned SMALL_DEPTH = 128;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0c;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTL_RD = 0;
  localparam int unsigned CTL_WR = 1;
  localparam int unsigned CTL_PERMIT = 2;
  localparam int unsigned CTL_ABORT = 3;
  localparam int unsigned FLAG_DONE = 7;
  localparam int unsigned STAT_PWRT = 0;
  localparam int unsigned STAT_BUSY = 1;

  ////////////////////////////////////////////////////////////////////////////
  // values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic RST_ABORT = 1'b0;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_SMALL = 8'h7f;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ERASE = 2'b01,
    WR_PROG = 2'b10
  } wr_state_e;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_GOT_FIRST = 2'b01,
    UNL_ARMED = 2'b10
  } unl_state_e;

endpackage

// [verilog/nv_array.sv]
// byte array with one write port and two combinational read ports
`timescale 1ns/1ns
`default_nettype none
module nv_array #(
  parameter int unsigned DEPTH = 256
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_byte,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_byte,
  input wire logic [7:0] prog_addr,
  output logic [7:0] prog_byte
);

  // no reset: contents are nonvolatile
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_byte;
    end
  end

  assign rd_byte = mem[rd_addr];
  assign prog_byte = mem[prog_addr];

endmodule
`default_nettype wire

// [verilog/unlock_tracker.sv]
// tracks the two key writes that must precede a write trigger
`timescale 1ns/1ns
`default_nettype none
module unlock_tracker
  import nv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic access,
  input wire logic key_write,
  input wire logic [7:0] key_byte,
  output logic armed
);

  unl_state_e state_ff;
  logic first_hit;
  logic second_hit;

  assign first_hit = key_write && (key_byte == KEY_FIRST);
  assign second_hit = key_write && (key_byte == KEY_SECOND);

  // each bus access is one instruction: any access between keys restarts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= UNL_IDLE;
    end else if (soft_rst) begin
      state_ff <= UNL_IDLE;
    end else if (access) begin
      case (state_ff)
        UNL_IDLE: begin
          state_ff <= first_hit ? UNL_GOT_FIRST : UNL_IDLE;
        end
        UNL_GOT_FIRST: begin
          if (second_hit) begin
            state_ff <= UNL_ARMED;
          end else begin
            state_ff <= first_hit ? UNL_GOT_FIRST : UNL_IDLE;
          end
        end
        default: begin
          state_ff <= first_hit ? UNL_GOT_FIRST : UNL_IDLE;
        end
      endcase
    end
  end

  assign armed = (state_ff == UNL_ARMED);

  a_armed_order: assert property (@(posedge core_clk) disable iff (rst)
    $rose(armed) |-> $past(state_ff) == UNL_GOT_FIRST && $past(second_hit))
    else $error("unlock armed without the key pair");

  a_idle_restart: assert property (@(posedge core_clk) disable iff (rst)
    access && !first_hit && !(second_hit && state_ff == UNL_GOT_FIRST) && !soft_rst
      |=> state_ff == UNL_IDLE)
    else $error("tracker kept progress after a foreign access");

endmodule
`default_nettype wire

// [verilog/nv_ctrl.sv]
// data eeprom access control: register slave, unlock, write timing, array
//
// Behaviour
// - byte register and index register select cell
// - 256 cells, or 128 with index msb zero
// - each write erases cell, then programs
// - internal timer sets write length, trigger held
// - protected array reads zero to programmer port
// - control register upper four bits read zero
// - triggers set only; hardware clears on completion
// - write permit cleared at power-up, software only
// - abort flag set when reset cuts write
// - aborting reset clears byte and index registers
// - completion clears trigger, sets sticky done flag
// - unlock key location stores nothing, reads zero
// - read trigger loads byte within one cycle
// - byte register keeps read value until replaced
// - keys 55h then AAh then write trigger
// - exact access count across unlock, else refused
// - write trigger refused without write permit
// - clearing permit never disturbs a running write
// - power-up timer blocks writes after power-on
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module nv_ctrl #(
  parameter int unsigned PWRT_CYCLES = nv_pkg::PWRT_CYCLES,
  parameter bit SMALL_ARRAY = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [nv_pkg::OFS_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [nv_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [nv_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer_rst,
  input wire logic brownout_reset,
  input wire logic data_protect,
  input wire logic prog_read,
  input wire logic [nv_pkg::BYTE_W-1:0] prog_index,
  output logic [nv_pkg::BYTE_W-1:0] prog_rdata
);
  import nv_pkg::*;

  localparam int unsigned DEPTH = SMALL_ARRAY ? SMALL_DEPTH : FULL_DEPTH;
  localparam logic [7:0] INDEX_MASK = SMALL_ARRAY ? MASK_SMALL : MASK_FULL;
  localparam logic [22:0] PWRT_LAST = 23'(PWRT_CYCLES - 1);

  logic wait_ff;
  logic [31:0] readdata_ff;
  logic [7:0] nv_data_byte_ff;
  logic [7:0] nv_cell_index_ff;
  logic rd_ff;
  logic wr_ff;
  logic write_permit_ff;
  logic write_abort_flag_ff;
  logic write_done_flag_ff;
  logic pwrt_active_ff;
  logic [22:0] pwrt_cnt_ff;
  wr_state_e wr_state_ff;
  logic [15:0] timer_ff;
  logic [7:0] latch_index_ff;
  logic [7:0] latch_byte_ff;
  logic [7:0] prog_rdata_ff;

  logic accept;
  logic wr_acc;
  logic soft_rst;
  logic sel_data;
  logic sel_index;
  logic sel_ctl;
  logic sel_key;
  logic sel_flag;
  logic armed;
  logic wr_start;
  logic wr_done;
  logic arr_wr_en;
  logic [7:0] arr_wr_byte;
  logic [7:0] arr_rd_byte;
  logic [7:0] arr_prog_byte;
  logic [7:0] read_mux;
  logic [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign accept = (avs_read || avs_write) && !wait_ff;
  assign wr_acc = accept && avs_write && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign soft_rst = external_reset_pin || watchdog_timer_rst || brownout_reset;
  assign sel_data = (avs_address == OFS_DATA);
  assign sel_index = (avs_address == OFS_INDEX);
  assign sel_ctl = (avs_address == OFS_CONTROL);
  assign sel_key = (avs_address == OFS_KEY);
  assign sel_flag = (avs_address == OFS_FLAG);

  // one wait cycle: waitrequest drops the edge after the request appears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_comb begin
    case (avs_address)
      OFS_DATA: read_mux = nv_data_byte_ff;
      OFS_INDEX: read_mux = nv_cell_index_ff & INDEX_MASK;
      OFS_CONTROL: read_mux = {4'h0, write_abort_flag_ff, write_permit_ff, wr_ff, rd_ff};
      OFS_KEY: read_mux = 8'h00;
      OFS_FLAG: read_mux = {write_done_flag_ff, 7'h00};
      OFS_STATUS: read_mux = {6'h00, wr_state_ff != WR_IDLE, pwrt_active_ff};
      default: read_mux = 8'h00;
    endcase
  end

  // read data sampled when waitrequest drops, stands through the accept edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readdata_ff <= 32'h0;
    end else if (avs_read && wait_ff) begin
      readdata_ff <= {24'h0, read_mux};
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence

  unlock_tracker u_unlock (
    .core_clk(core_clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .access(accept),
    .key_write(wr_acc && sel_key),
    .key_byte(wbyte),
    .armed(armed)
  );

  assign wr_start = wr_acc && sel_ctl && wbyte[CTL_WR] && write_permit_ff
    && armed && !pwrt_active_ff && !wr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // power-up timer

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwrt_cnt_ff <= 23'h0;
      pwrt_active_ff <= 1'b1;
    end else if (pwrt_active_ff) begin
      pwrt_cnt_ff <= pwrt_cnt_ff + 23'h1;
      if (pwrt_cnt_ff == PWRT_LAST) begin
        pwrt_active_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data and index registers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_data_byte_ff <= RST_DATA;
    end else if (soft_rst) begin
      nv_data_byte_ff <= RST_DATA;
    end else if (rd_ff) begin
      nv_data_byte_ff <= arr_rd_byte;
    end else if (wr_acc && sel_data) begin
      nv_data_byte_ff <= wbyte;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_cell_index_ff <= RST_INDEX;
    end else if (soft_rst) begin
      nv_cell_index_ff <= RST_INDEX;
    end else if (wr_acc && sel_index) begin
      nv_cell_index_ff <= wbyte & INDEX_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  // read trigger lives exactly one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_ff <= 1'b0;
    end else if (soft_rst || rd_ff) begin
      rd_ff <= 1'b0;
    end else if (wr_acc && sel_ctl && wbyte[CTL_RD]) begin
      rd_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ff <= 1'b0;
    end else if (soft_rst || wr_done) begin
      wr_ff <= 1'b0;
    end else if (wr_start) begin
      wr_ff <= 1'b1;
    end
  end

  // of the resets only power-on clears it; the write machine never looks at it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_permit_ff <= 1'b0;
    end else if (wr_acc && sel_ctl) begin
      write_permit_ff <= wbyte[CTL_PERMIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_abort_flag_ff <= RST_ABORT;
    end else if (soft_rst && wr_ff) begin
      write_abort_flag_ff <= 1'b1;
    end else if (wr_done) begin
      write_abort_flag_ff <= 1'b0;
    end else if (wr_acc && sel_ctl) begin
      write_abort_flag_ff <= wbyte[CTL_ABORT];
    end
  end

  // completion wins over a software clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_done_flag_ff <= 1'b0;
    end else if (soft_rst) begin
      write_done_flag_ff <= 1'b0;
    end else if (wr_done) begin
      write_done_flag_ff <= 1'b1;
    end else if (wr_acc && sel_flag) begin
      write_done_flag_ff <= wbyte[FLAG_DONE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write cycle: erase half then program half, timed on chip

  assign wr_done = (wr_state_ff == WR_PROG) && (timer_ff == PROG_LAST) && !soft_rst;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_state_ff <= WR_IDLE;
      timer_ff <= 16'h0;
    end else if (soft_rst) begin
      wr_state_ff <= WR_IDLE;
      timer_ff <= 16'h0;
    end else begin
      case (wr_state_ff)
        WR_IDLE: begin
          timer_ff <= 16'h0;
          if (wr_start) begin
            wr_state_ff <= WR_ERASE;
          end
        end
        WR_ERASE: begin
          if (timer_ff == ERASE_LAST) begin
            wr_state_ff <= WR_PROG;
            timer_ff <= 16'h0;
          end else begin
            timer_ff <= timer_ff + 16'h1;
          end
        end
        WR_PROG: begin
          if (timer_ff == PROG_LAST) begin
            wr_state_ff <= WR_IDLE;
            timer_ff <= 16'h0;
          end else begin
            timer_ff <= timer_ff + 16'h1;
          end
        end
        default: begin
          wr_state_ff <= WR_IDLE;
          timer_ff <= 16'h0;
        end
      endcase
    end
  end

  // latched so a stray register write cannot retarget a running cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_index_ff <= RST_INDEX;
      latch_byte_ff <= RST_DATA;
    end else if (wr_start) begin
      latch_index_ff <= nv_cell_index_ff;
      latch_byte_ff <= nv_data_byte_ff;
    end
  end

  assign arr_wr_en = ((wr_state_ff == WR_ERASE) && (timer_ff == 16'h0)) || wr_done;
  assign arr_wr_byte = (wr_state_ff == WR_ERASE) ? ERASED_BYTE : latch_byte_ff;

  nv_array #(
    .DEPTH(DEPTH)
  ) u_array (
    .core_clk(core_clk),
    .wr_en(arr_wr_en),
    .wr_addr(latch_index_ff),
    .wr_byte(arr_wr_byte),
    .rd_addr(nv_cell_index_ff),
    .rd_byte(arr_rd_byte),
    .prog_addr(prog_index & INDEX_MASK),
    .prog_byte(arr_prog_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // programmer read port

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prog_rdata_ff <= 8'h00;
    end else if (prog_read) begin
      prog_rdata_ff <= data_protect ? 8'h00 : arr_prog_byte;
    end
  end

  assign prog_rdata = prog_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] wr_len_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_len_ff <= 16'h0;
    end else if (!wr_ff) begin
      wr_len_ff <= 16'h0;
    end else begin
      wr_len_ff <= wr_len_ff + 16'h1;
    end
  end

  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    rd_ff && !soft_rst |=> !rd_ff && nv_data_byte_ff == $past(arr_rd_byte))
    else $error("read trigger did not load the byte in one cycle");

  a_permit_gate: assert property (@(posedge core_clk) disable iff (rst)
    $rose(wr_ff) |-> $past(write_permit_ff) && $past(armed))
    else $error("write started without permit or unlock");

  a_write_length: assert property (@(posedge core_clk) disable iff (rst)
    wr_done |-> wr_len_ff == 16'(WRITE_CYCLES - 1))
    else $error("write cycle length wrong");

  a_trigger_held: assert property (@(posedge core_clk) disable iff (rst)
    wr_ff && !wr_done && !soft_rst |=> wr_ff)
    else $error("write trigger dropped early");

  a_done_flag: assert property (@(posedge core_clk) disable iff (rst)
    wr_done |=> write_done_flag_ff && !wr_ff && !write_abort_flag_ff)
    else $error("completion not reported");

  a_abort_flag: assert property (@(posedge core_clk) disable iff (rst)
    soft_rst && wr_ff |=> write_abort_flag_ff && !wr_ff
      && nv_data_byte_ff == RST_DATA && nv_cell_index_ff == RST_INDEX)
    else $error("aborted write not flagged or registers kept");

  a_pwrt_block: assert property (@(posedge core_clk) disable iff (rst)
    pwrt_active_ff |=> !$rose(wr_ff))
    else $error("write started under power-up timer");

  a_ctl_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
    accept && avs_read && sel_ctl |-> readdata_ff[31:4] == 28'h0)
    else $error("control upper bits not zero");

  a_key_zero: assert property (@(posedge core_clk) disable iff (rst)
    accept && avs_read && sel_key |-> readdata_ff == 32'h0)
    else $error("key location read nonzero");

  a_permit_kept: assert property (@(posedge core_clk) disable iff (rst)
    !(wr_acc && sel_ctl) |=> write_permit_ff == $past(write_permit_ff))
    else $error("write permit changed without software");

  a_prog_protect: assert property (@(posedge core_clk) disable iff (rst)
    prog_read && data_protect |=> prog_rdata_ff == 8'h00)
    else $error("protected array leaked to programmer");

  a_wait_one: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("waitrequest timing wrong");

  c_write_done: cover property (@(posedge core_clk) disable iff (rst) wr_done);
  c_write_abort: cover property (@(posedge core_clk) disable iff (rst) soft_rst && wr_ff);
  c_read: cover property (@(posedge core_clk) disable iff (rst) rd_ff);
  c_refused: cover property (@(posedge core_clk) disable iff (rst)
    wr_acc && sel_ctl && wbyte[CTL_WR] && !armed);

endmodule
`default_nettype wire

// [bench/core_model.sv]
// processor core model: register bus master running firmware sequences
`timescale 1ns/1ns
`default_nettype none
module core_model
  import nv_pkg::*;
(
  input wire logic core_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
  end
  //////////////////////////////////////////////////////////////////////////
  // one cycle; request held until waitrequest sampled low
  task automatic access(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
      output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, wd};
    // no cycle limit here: a hung slave is caught by the bench watchdog
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic put(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    access(1'b1, adr, wd, d);
  endtask
  task automatic get(input logic [7:0] adr, output logic [31:0] rd);
    access(1'b0, adr, 8'h00, rd);
  endtask
  // nothing may slip in between, as with interrupts off
  task automatic unlock(input logic [7:0] ctl);
    put(OFS_KEY, KEY_FIRST);
    put(OFS_KEY, KEY_SECOND);
    put(OFS_CONTROL, ctl);
  endtask
  // only polls while busy, never writes
  task automatic wait_idle();
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      get(OFS_CONTROL, d);
      n++;
    end while (d[CTL_WR] === 1'b1 && n < 300);
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the data eeprom access control
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import nv_pkg::*;
  localparam int unsigned PWRT = 60;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic external_reset_pin = 1'b0;
  logic watchdog_timer_rst = 1'b0;
  logic brownout_reset = 1'b0;
  logic data_protect = 1'b0;
  logic prog_read = 1'b0;
  logic [7:0] prog_index = 8'h00;
  logic [7:0] prog_rdata;
  logic [7:0] mem [int];
  logic [31:0] seed = 32'd87663;
  logic [7:0] idx;
  longint t0;
  int n_fail = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  core_model core (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  nv_ctrl #(.PWRT_CYCLES(PWRT), .SMALL_ARRAY(1'b0)) dut (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_reset_pin(external_reset_pin), .watchdog_timer_rst(watchdog_timer_rst),
    .brownout_reset(brownout_reset), .data_protect(data_protect), .prog_read(prog_read),
    .prog_index(prog_index), .prog_rdata(prog_rdata));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    core.get(adr, d);
    check(d, {24'h000000, exp});
  endtask
  task automatic ee_write(input logic [7:0] i, input logic [7:0] v);
    core.put(OFS_INDEX, i);
    core.put(OFS_DATA, v);
    rchk(OFS_INDEX, i);
    core.unlock(8'h06);
    t0 = $time;
    rchk(OFS_CONTROL, 8'h06);
    rchk(OFS_STATUS, 8'h02);
    core.wait_idle();
    t0 = ($time - t0) / 10;
    check(32'(t0 >= WRITE_CYCLES && t0 <= WRITE_CYCLES + 10), 32'h1);
    rchk(OFS_CONTROL, 8'h04);
    rchk(OFS_FLAG, 8'h80);
    core.put(OFS_FLAG, 8'h00);
    rchk(OFS_FLAG, 8'h00);
    mem[i] = v;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rchk(OFS_STATUS, 8'h01);
    rchk(OFS_CONTROL, 8'h00);
    rchk(OFS_DATA, 8'h00);
    rchk(OFS_INDEX, 8'h00);
    rchk(8'h18, 8'h00);
    core.put(OFS_CONTROL, 8'hf4);
    core.unlock(8'h06);
    rchk(OFS_CONTROL, 8'h04);
    repeat (PWRT) @(posedge core_clk);
    rchk(OFS_STATUS, 8'h00);
    core.put(OFS_KEY, KEY_FIRST);
    rchk(OFS_KEY, 8'h00);
    core.put(OFS_CONTROL, 8'h00);
    core.unlock(8'h02);
    rchk(OFS_CONTROL, 8'h00);
    core.put(OFS_CONTROL, 8'h04);
    core.put(OFS_KEY, KEY_SECOND);
    core.put(OFS_KEY, KEY_FIRST);
    core.put(OFS_CONTROL, 8'h06);
    rchk(OFS_CONTROL, 8'h04);
    core.put(OFS_KEY, KEY_FIRST);
    rchk(OFS_DATA, 8'h00);
    core.put(OFS_KEY, KEY_SECOND);
    core.put(OFS_CONTROL, 8'h06);
    rchk(OFS_CONTROL, 8'h04);
    rchk(OFS_FLAG, 8'h00);
    for (int i = 0; i < 3; i++) begin
      idx = (i == 0) ? 8'hff : rnd();
      ee_write(idx, rnd());
      ee_write(idx, ~mem[idx]);
      core.put(OFS_INDEX, idx);
      core.put(OFS_CONTROL, 8'h05);
      rchk(OFS_CONTROL, 8'h04);
      rchk(OFS_DATA, mem[idx]);
      core.put(OFS_CONTROL, 8'h04);
      rchk(OFS_DATA, mem[idx]);
      for (int p = 0; p < 2; p++) begin
        @(posedge core_clk);
        data_protect <= p[0];
        prog_index <= idx;
        prog_read <= 1'b1;
        @(posedge core_clk);
        prog_read <= 1'b0;
        @(posedge core_clk);
        check({24'h000000, prog_rdata}, (p == 1) ? 32'h0 : {24'h000000, mem[idx]});
      end
    end
    // each reset cause cuts a running write
    for (int k = 0; k < 3; k++) begin
      core.put(OFS_INDEX, 8'h11);
      core.put(OFS_DATA, 8'h5a);
      core.unlock(8'h06);
      repeat (20) @(posedge core_clk);
      {external_reset_pin, watchdog_timer_rst, brownout_reset} <= 3'b100 >> k;
      @(posedge core_clk);
      {external_reset_pin, watchdog_timer_rst, brownout_reset} <= 3'b000;
      rchk(OFS_CONTROL, 8'h0c);
      rchk(OFS_DATA, 8'h00);
      rchk(OFS_INDEX, 8'h00);
      core.put(OFS_CONTROL, 8'h04);
      rchk(OFS_CONTROL, 8'h04);
    end
    summarize();
  end
endmodule
`default_nettype wire
